// ---- common/dtd_pkg.sv ----
`default_nettype none

package dtd_pkg;

  typedef struct packed {
    logic on;
    logic polySel;
    logic invert;
    logic clear;
  } dtd_chk_cfg_s;

  typedef struct packed {
    logic [7:0] errCount;
    logic       pass;
  } dtd_chk_stat_s;

  typedef enum logic [1:0] {
    DTD_IDLE  = 2'b00,
    DTD_INSTR = 2'b01,
    DTD_DATA  = 2'b10,
    DTD_DONE  = 2'b11
  } dtd_spi_state_e;

  typedef struct packed {
    logic        strobe;
    logic [14:0] addr;
    logic [7:0]  data;
  } dtd_write_s;

endpackage : dtd_pkg

`default_nettype wire

// ---- common/dtd_regs.svh ----
// Functional notes
// - Poly select 0 checks x^7+x^6+1 sequence
// - Real channel error count, 8-bit read-only
// - Imaginary channel error count, separate 8-bit read-only
// - Upper segment shuffle bit 2, else thermometer
// - Independent middle and double-rate shuffle enables
// - Two-bit output encoding: NRZ, mixing, RZ
// - Config port outputs: slew low, drive high
// - Master powerdown bit, resets to powered down
// - Per-lane powerdown override, bit n lane n
// - Pass flags imaginary bit 7, real 6
// - Per-channel expect-inverted bits, reset to 0
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DTD_ADDR_PATTERN_CTRL  15'h014B
`define DTD_ADDR_ERR_REAL      15'h014C
`define DTD_ADDR_ERR_IMAG      15'h014D
`define DTD_ADDR_SHUFFLE       15'h0151
`define DTD_ADDR_ENCODING      15'h0152
`define DTD_ADDR_DRIVE         15'h01DF
`define DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN     15'h0200
`define DTD_ADDR_LANE_PHY_POWERDOWN        15'h0201

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTD_BIT_PASS_IMAG      7
`define DTD_BIT_PASS_REAL      6
`define DTD_BIT_INV_IMAG       4
`define DTD_BIT_INV_REAL       3
`define DTD_BIT_POLY_SEL       2
`define DTD_BIT_ERR_CLEAR      1
`define DTD_BIT_CHECK_ON       0
`define DTD_BIT_SHUFFLE_UPPER  2
`define DTD_BIT_SHUFFLE_MIDDLE 1
`define DTD_BIT_SHUFFLE_DDR    0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define DTD_RST_DRIVE          4'hF
`define DTD_RST_SERIAL_RX_MASTER_POWERDOWN      1'h1
`define DTD_RST_LANE_PHY_POWERDOWN         8'h00
`define DTD_ENC_RESERVED       2'h3

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define DTD_INSTR_BITS         5'h10
`define DTD_DATA_BITS          5'h08
`define DTD_PASS_RUN           5'h10
`define DTD_PRIME_SHORT        4'h7
`define DTD_PRIME_LONG         4'hF

`endif

// ---- core/dtd_pattern_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtd_regs.svh"

module dtd_pattern_checker (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire dtd_pkg::dtd_chk_cfg_s  cfg,
  input  wire logic                   bitValid,
  input  wire logic                   bitIn,
  output var dtd_pkg::dtd_chk_stat_s  status
);

  logic [14:0] history;
  logic [3:0]  primeCount;
  logic [4:0]  runCount;
  logic        rxBit;
  logic        predicted;
  logic        primed;
  logic        checkNow;
  logic [7:0]  errCount;
  logic        passFlag;

  assign status = '{errCount: errCount, pass: passFlag};

  // ----------------------------------------------------------------
  // Prediction
  // ----------------------------------------------------------------
  assign rxBit     = bitIn ^ cfg.invert;
  // Select 1 runs the 15-bit sequence x^15+x^14+1
  assign predicted = cfg.polySel ? (history[14] ^ history[13])
                                 : (history[6] ^ history[5]);
  assign primed    = primeCount >= (cfg.polySel ? `DTD_PRIME_LONG : `DTD_PRIME_SHORT);
  assign checkNow  = cfg.on && bitValid && primed;

  // ----------------------------------------------------------------
  // History and priming
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !cfg.on) begin
      history    <= 15'h0000;
      primeCount <= 4'h0;
    end else if (bitValid) begin
      history <= {history[13:0], rxBit};
      if (primeCount != `DTD_PRIME_LONG) begin
        primeCount <= primeCount + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error count; clear holds it at zero for as long as it is set
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || cfg.clear) begin
      errCount <= 8'h00;
    end else if (checkNow && (rxBit != predicted) && (errCount != 8'hFF)) begin
      errCount <= errCount + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pass flag needs a clean run so a lucky bit cannot raise it
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !cfg.on) begin
      passFlag <= 1'b0;
      runCount <= 5'h00;
    end else if (checkNow) begin
      if (rxBit != predicted) begin
        passFlag <= 1'b0;
        runCount <= 5'h00;
      end else if (runCount == `DTD_PASS_RUN) begin
        passFlag <= 1'b1;
      end else begin
        runCount <= runCount + 5'h01;
      end
    end
  end

endmodule : dtd_pattern_checker
`default_nettype wire

// ---- core/dtd_reg_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtd_regs.svh"

module dtd_reg_bank (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        spiClk,
  input  wire logic        spiSelectN,
  input  wire logic        spiDataIn,
  output logic             spiDataOut,
  output logic             spiDataOutEn,
  input  wire logic        patternValid,
  input  wire logic        patternBitReal,
  input  wire logic        patternBitImag,
  output logic             shuffleUpper,
  output logic             middleSegmentScramble,
  output logic             shuffleDoubleRate,
  output logic [1:0]       outputEncoding,
  output logic [3:0]       cfgPortSlewDrive,
  output logic             rxAnalogPowerdownAll,
  output logic [7:0]       lanePhyPowerdownMask,
  output logic [7:0]       lanePhyOff
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclkMeta;
  logic sclkSync;
  logic sclkLast;
  logic selMeta;
  logic selSync;
  logic sdiMeta;
  logic sdiSync;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      selMeta  <= 1'b1;
      selSync  <= 1'b1;
      sdiMeta  <= 1'b0;
      sdiSync  <= 1'b0;
    end else begin
      sclkMeta <= spiClk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      selMeta  <= spiSelectN;
      selSync  <= selMeta;
      sdiMeta  <= spiDataIn;
      sdiSync  <= sdiMeta;
    end
  end

  logic sclkRise;
  logic sclkFall;

  assign sclkRise = sclkSync && !sclkLast;
  assign sclkFall = !sclkSync && sclkLast;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       checkOn;
  logic       polySel;
  logic       errClear;
  logic       expectInvertedReal;
  logic       expectInvertedImag;

  dtd_pkg::dtd_write_s   wr;
  dtd_pkg::dtd_chk_cfg_s cfgReal;
  dtd_pkg::dtd_chk_cfg_s cfgImag;
  dtd_pkg::dtd_chk_stat_s statReal;
  dtd_pkg::dtd_chk_stat_s statImag;

  always_ff @(posedge clk) begin
    if (reset) begin
      checkOn            <= 1'b0;
      polySel            <= 1'b0;
      errClear           <= 1'b0;
      expectInvertedReal <= 1'b0;
      expectInvertedImag <= 1'b0;
    end else if (wr.strobe && wr.addr == `DTD_ADDR_PATTERN_CTRL) begin
      checkOn            <= wr.data[`DTD_BIT_CHECK_ON];
      polySel            <= wr.data[`DTD_BIT_POLY_SEL];
      errClear           <= wr.data[`DTD_BIT_ERR_CLEAR];
      expectInvertedReal <= wr.data[`DTD_BIT_INV_REAL];
      expectInvertedImag <= wr.data[`DTD_BIT_INV_IMAG];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shuffleUpper          <= 1'b0;
      middleSegmentScramble <= 1'b0;
      shuffleDoubleRate     <= 1'b0;
    end else if (wr.strobe && wr.addr == `DTD_ADDR_SHUFFLE) begin
      shuffleUpper          <= wr.data[`DTD_BIT_SHUFFLE_UPPER];
      middleSegmentScramble <= wr.data[`DTD_BIT_SHUFFLE_MIDDLE];
      shuffleDoubleRate     <= wr.data[`DTD_BIT_SHUFFLE_DDR];
    end
  end

  // The reserved code is refused so the output stage never sees it
  always_ff @(posedge clk) begin
    if (reset) begin
      outputEncoding <= 2'h0;
    end else if (wr.strobe && wr.addr == `DTD_ADDR_ENCODING
                 && wr.data[1:0] != `DTD_ENC_RESERVED) begin
      outputEncoding <= wr.data[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfgPortSlewDrive <= `DTD_RST_DRIVE;
    end else if (wr.strobe && wr.addr == `DTD_ADDR_DRIVE) begin
      cfgPortSlewDrive <= wr.data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxAnalogPowerdownAll <= `DTD_RST_SERIAL_RX_MASTER_POWERDOWN;
    end else if (wr.strobe && wr.addr == `DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN) begin
      rxAnalogPowerdownAll <= wr.data[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lanePhyPowerdownMask <= `DTD_RST_LANE_PHY_POWERDOWN;
    end else if (wr.strobe && wr.addr == `DTD_ADDR_LANE_PHY_POWERDOWN) begin
      lanePhyPowerdownMask <= wr.data;
    end
  end

  // Effective lane state: master bit takes all eight lanes with it
  always_ff @(posedge clk) begin
    if (reset) begin
      lanePhyOff <= 8'hFF;
    end else begin
      lanePhyOff <= lanePhyPowerdownMask | {8{rxAnalogPowerdownAll}};
    end
  end

  // ----------------------------------------------------------------
  // Pattern checkers
  // ----------------------------------------------------------------
  assign cfgReal = '{on: checkOn, polySel: polySel, invert: expectInvertedReal,
                     clear: errClear};
  assign cfgImag = '{on: checkOn, polySel: polySel, invert: expectInvertedImag,
                     clear: errClear};

  dtd_pattern_checker u_check_real (
    .clk      (clk),
    .reset    (reset),
    .cfg      (cfgReal),
    .bitValid (patternValid),
    .bitIn    (patternBitReal),
    .status   (statReal)
  );

  dtd_pattern_checker u_check_imag (
    .clk      (clk),
    .reset    (reset),
    .cfg      (cfgImag),
    .bitValid (patternValid),
    .bitIn    (patternBitImag),
    .status   (statImag)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] readValue(input logic [14:0] addr);
    logic [7:0] value;
    value = 8'h00;
    if (addr == `DTD_ADDR_PATTERN_CTRL) begin
      value[`DTD_BIT_PASS_IMAG] = statImag.pass;
      value[`DTD_BIT_PASS_REAL] = statReal.pass;
      value[`DTD_BIT_INV_IMAG]  = expectInvertedImag;
      value[`DTD_BIT_INV_REAL]  = expectInvertedReal;
      value[`DTD_BIT_POLY_SEL]  = polySel;
      value[`DTD_BIT_ERR_CLEAR] = errClear;
      value[`DTD_BIT_CHECK_ON]  = checkOn;
    end else if (addr == `DTD_ADDR_ERR_REAL) begin
      value = statReal.errCount;
    end else if (addr == `DTD_ADDR_ERR_IMAG) begin
      value = statImag.errCount;
    end else if (addr == `DTD_ADDR_SHUFFLE) begin
      value[`DTD_BIT_SHUFFLE_UPPER]  = shuffleUpper;
      value[`DTD_BIT_SHUFFLE_MIDDLE] = middleSegmentScramble;
      value[`DTD_BIT_SHUFFLE_DDR]    = shuffleDoubleRate;
    end else if (addr == `DTD_ADDR_ENCODING) begin
      value[1:0] = outputEncoding;
    end else if (addr == `DTD_ADDR_DRIVE) begin
      value[3:0] = cfgPortSlewDrive;
    end else if (addr == `DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN) begin
      value[0] = rxAnalogPowerdownAll;
    end else if (addr == `DTD_ADDR_LANE_PHY_POWERDOWN) begin
      value = lanePhyPowerdownMask;
    end
    return value;
  endfunction : readValue

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  // Select high always ends the frame, so a host that aborts mid-byte
  // leaves no partial write behind.
  dtd_pkg::dtd_spi_state_e state;
  logic [4:0]  bitCount;
  logic [14:0] shiftIn;
  logic [7:0]  shiftOut;
  logic        isRead;
  logic [14:0] frameAddr;
  logic [14:0] instrAddr;
  logic [7:0]  readNow;

  assign instrAddr = {shiftIn[13:0], sdiSync};

  always_comb begin
    readNow = readValue(instrAddr);
  end

  always_ff @(posedge clk) begin
    if (reset || selSync) begin
      state     <= dtd_pkg::DTD_IDLE;
      bitCount  <= 5'h00;
      shiftIn   <= 15'h0000;
      isRead    <= 1'b0;
      frameAddr <= 15'h0000;
    end else begin
      case (state)
        dtd_pkg::DTD_IDLE: begin
          state    <= dtd_pkg::DTD_INSTR;
          bitCount <= 5'h00;
        end
        dtd_pkg::DTD_INSTR: begin
          if (sclkRise) begin
            shiftIn  <= {shiftIn[13:0], sdiSync};
            bitCount <= bitCount + 5'h01;
            if (bitCount == `DTD_INSTR_BITS - 5'h01) begin
              isRead    <= shiftIn[14];
              frameAddr <= instrAddr;
              bitCount  <= 5'h00;
              state     <= dtd_pkg::DTD_DATA;
            end
          end
        end
        dtd_pkg::DTD_DATA: begin
          if (sclkRise) begin
            shiftIn  <= {shiftIn[13:0], sdiSync};
            bitCount <= bitCount + 5'h01;
            if (bitCount == `DTD_DATA_BITS - 5'h01) begin
              state <= dtd_pkg::DTD_DONE;
            end
          end
        end
        dtd_pkg::DTD_DONE: begin
          state <= dtd_pkg::DTD_DONE;
        end
        default: begin
          state <= dtd_pkg::DTD_IDLE;
        end
      endcase
    end
  end

  // Write strobe fires once, on the eighth data bit of a write frame
  always_ff @(posedge clk) begin
    if (reset) begin
      wr <= '0;
    end else begin
      wr.strobe <= !selSync && state == dtd_pkg::DTD_DATA && sclkRise && !isRead
                   && bitCount == `DTD_DATA_BITS - 5'h01;
      wr.addr   <= frameAddr;
      wr.data   <= {shiftIn[6:0], sdiSync};
    end
  end

  // Read data is sampled at the end of the instruction, then shifted
  // out on falling clock edges so it is stable at the host's rising edge.
  always_ff @(posedge clk) begin
    if (reset || selSync) begin
      shiftOut     <= 8'h00;
      spiDataOut   <= 1'b0;
      spiDataOutEn <= 1'b0;
    end else if (state == dtd_pkg::DTD_INSTR && sclkRise
                 && bitCount == `DTD_INSTR_BITS - 5'h01) begin
      // First data-phase fall re-presents bit 7 for the host's next rise
      shiftOut     <= readNow;
      spiDataOut   <= readNow[7];
      spiDataOutEn <= shiftIn[14];
    end else if (state == dtd_pkg::DTD_DATA && sclkFall && isRead) begin
      spiDataOut <= shiftOut[7];
      shiftOut   <= {shiftOut[6:0], 1'b0};
    end else if (state == dtd_pkg::DTD_DONE && sclkFall) begin
      spiDataOutEn <= 1'b0;
    end
  end

endmodule : dtd_reg_bank
`default_nettype wire

// ---- tb/dtd_reg_bank_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module dtd_reg_bank_assertions (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       spiSelectN,
  input wire logic       spiDataOutEn,
  input wire logic       shuffleUpper,
  input wire logic       middleSegmentScramble,
  input wire logic       shuffleDoubleRate,
  input wire logic [1:0] outputEncoding,
  input wire logic [3:0] cfgPortSlewDrive,
  input wire logic       rxAnalogPowerdownAll,
  input wire logic [7:0] lanePhyPowerdownMask,
  input wire logic [7:0] lanePhyOff
);
  // ------------------------------------------------------------
  // Register outputs
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_decode: assert property ($fell(reset) |->
      {shuffleUpper, middleSegmentScramble, shuffleDoubleRate, outputEncoding} == 5'h00)
    else $error("decode outputs not at reset values");
  a_reset_drive: assert property ($fell(reset) |-> cfgPortSlewDrive == 4'hF)
    else $error("drive field not at reset value");
  a_reset_power: assert property ($fell(reset) |->
      rxAnalogPowerdownAll && lanePhyPowerdownMask == 8'h00 && lanePhyOff == 8'hFF)
    else $error("powerdown outputs not at reset values");
  a_enc_no_reserved: assert property (outputEncoding != 2'h3)
    else $error("reserved encoding reached the output");
  a_phy_off_merge: assert property (
      lanePhyOff == ($past(lanePhyPowerdownMask) | {8{$past(rxAnalogPowerdownAll)}}))
    else $error("lane off vector does not merge mask and master");
  a_master_forces_off: assert property (rxAnalogPowerdownAll |=> lanePhyOff == 8'hFF)
    else $error("master powerdown left a lane running");
  // Settings may only move while a frame is open
  a_idle_cfg_stable: assert property (spiSelectN [*8] |->
      $stable({shuffleUpper, middleSegmentScramble, shuffleDoubleRate, outputEncoding,
               cfgPortSlewDrive}))
    else $error("decode or drive setting moved without a frame");
  a_idle_pwr_stable: assert property (spiSelectN [*8] |->
      $stable({rxAnalogPowerdownAll, lanePhyPowerdownMask, lanePhyOff}))
    else $error("powerdown setting moved without a frame");

  c_shuffle_on: cover property ($rose(shuffleUpper));
  c_read_phase: cover property ($rose(spiDataOutEn));
  c_rz_mode: cover property (outputEncoding == 2'h2);
  c_lanes_partial: cover property (!rxAnalogPowerdownAll && lanePhyOff == 8'hA5);
endmodule : dtd_reg_bank_assertions

bind dtd_reg_bank dtd_reg_bank_assertions u_chk (.clk(clk), .reset(reset),
  .spiSelectN(spiSelectN), .spiDataOutEn(spiDataOutEn), .shuffleUpper(shuffleUpper),
  .middleSegmentScramble(middleSegmentScramble), .shuffleDoubleRate(shuffleDoubleRate),
  .outputEncoding(outputEncoding), .cfgPortSlewDrive(cfgPortSlewDrive),
  .rxAnalogPowerdownAll(rxAnalogPowerdownAll),
  .lanePhyPowerdownMask(lanePhyPowerdownMask), .lanePhyOff(lanePhyOff));

`default_nettype wire

// ---- tb/dtd_reg_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtd_regs.svh"

module dtd_reg_bank_tb;
  logic        clk, reset, spiClk, spiSelectN, spiDataIn, spiDataOut, spiDataOutEn;
  logic        patternValid, patternBitReal, patternBitImag, rxAnalogPowerdownAll;
  logic        shuffleUpper, middleSegmentScramble, shuffleDoubleRate;
  logic [1:0]  outputEncoding;
  logic [3:0]  cfgPortSlewDrive;
  logic [7:0]  lanePhyPowerdownMask, lanePhyOff;
  logic [14:0] lfsr;
  logic        genBit, poly15, invReal, invImag, hitReal;
  int          nFail, nTests, cycles;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  dtd_reg_bank u_dut (.clk(clk), .reset(reset), .spiClk(spiClk), .spiSelectN(spiSelectN),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn),
    .patternValid(patternValid), .patternBitReal(patternBitReal),
    .patternBitImag(patternBitImag), .shuffleUpper(shuffleUpper),
    .middleSegmentScramble(middleSegmentScramble), .shuffleDoubleRate(shuffleDoubleRate),
    .outputEncoding(outputEncoding), .cfgPortSlewDrive(cfgPortSlewDrive),
    .rxAnalogPowerdownAll(rxAnalogPowerdownAll), .lanePhyPowerdownMask(lanePhyPowerdownMask),
    .lanePhyOff(lanePhyOff));

  dtd_spi_host u_host (.clk(clk), .spiClk(spiClk), .spiSelectN(spiSelectN),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn));

  // ------------------------------------------------------------
  // Test pattern source, one bit per channel each clk
  // ------------------------------------------------------------
  assign genBit = poly15 ? lfsr[14] ^ lfsr[13] : lfsr[6] ^ lfsr[5];
  always @(posedge clk) begin
    #1;
    patternBitReal = genBit ^ invReal ^ hitReal;
    patternBitImag = genBit ^ invImag;
    hitReal = 1'b0;
    lfsr = {lfsr[13:0], genBit};
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      nFail++;
      stopTest;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(1'b0, a, d, 24, x);
  endtask : wr

  task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] x;
    u_host.xfer(1'b1, a, 8'h00, 24, x);
    chk(x, exp);
  endtask : rdc

  task automatic tResetValues;
    rdc(`DTD_ADDR_PATTERN_CTRL, 8'h00);
    rdc(`DTD_ADDR_ERR_REAL, 8'h00);
    rdc(`DTD_ADDR_ERR_IMAG, 8'h00);
    rdc(`DTD_ADDR_SHUFFLE, 8'h00);
    rdc(`DTD_ADDR_ENCODING, 8'h00);
    rdc(`DTD_ADDR_DRIVE, 8'h0F);
    rdc(`DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN, 8'h01);
    rdc(`DTD_ADDR_LANE_PHY_POWERDOWN, 8'h00);
    chk(lanePhyOff, 8'hFF);
    $display("test reset values done");
  endtask : tResetValues

  task automatic tDecode;
    logic [1:0] encNow;
    for (int i = 0; i < 3; i++) begin
      wr(`DTD_ADDR_SHUFFLE, 8'h01 << i);
      chk({5'h00, shuffleUpper, middleSegmentScramble, shuffleDoubleRate}, 8'h01 << i);
    end
    wr(`DTD_ADDR_SHUFFLE, 8'hFF);
    rdc(`DTD_ADDR_SHUFFLE, 8'h07);
    encNow = 2'h0;
    // Code 3 comes last so the refused write must keep the return-to-zero code
    for (int m = 0; m < 4; m++) begin
      wr(`DTD_ADDR_ENCODING, 8'hFC | m[7:0]);
      if (m != 3) encNow = m[1:0];
      chk({6'h00, outputEncoding}, {6'h00, encNow});
      rdc(`DTD_ADDR_ENCODING, {6'h00, encNow});
    end
    $display("test decode done");
  endtask : tDecode

  task automatic tDrivePower;
    logic [7:0] x;
    wr(`DTD_ADDR_DRIVE, 8'hF6);
    chk({4'h0, cfgPortSlewDrive}, 8'h06);
    rdc(`DTD_ADDR_DRIVE, 8'h06);
    wr(`DTD_ADDR_LANE_PHY_POWERDOWN, 8'hA5);
    chk(lanePhyOff, 8'hFF);
    wr(`DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN, 8'hFE);
    chk(lanePhyOff, 8'hA5);
    rdc(`DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN, 8'h00);
    rdc(`DTD_ADDR_LANE_PHY_POWERDOWN, 8'hA5);
    wr(`DTD_ADDR_SERIAL_RX_MASTER_POWERDOWN, 8'h01);
    chk({7'h00, rxAnalogPowerdownAll}, 8'h01);
    chk(lanePhyOff, 8'hFF);
    wr(`DTD_ADDR_ERR_REAL, 8'h55);
    rdc(`DTD_ADDR_ERR_REAL, 8'h00);
    rdc(15'h0150, 8'h00);
    u_host.xfer(1'b0, `DTD_ADDR_SHUFFLE, 8'h00, 20, x);
    chk({5'h00, shuffleUpper, middleSegmentScramble, shuffleDoubleRate}, 8'h07);
    $display("test drive and power done");
  endtask : tDrivePower

  task automatic tChecker;
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h01);
    repeat (60) @(posedge clk);
    rdc(`DTD_ADDR_PATTERN_CTRL, 8'hC1);
    // A single flipped bit is seen three times by the self-synchronising check
    @(negedge clk) hitReal = 1'b1;
    repeat (40) @(posedge clk);
    rdc(`DTD_ADDR_ERR_REAL, 8'h03);
    rdc(`DTD_ADDR_ERR_IMAG, 8'h00);
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h03);
    rdc(`DTD_ADDR_ERR_REAL, 8'h00);
    @(negedge clk) invImag = 1'b1;
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h01);
    repeat (300) @(posedge clk);
    rdc(`DTD_ADDR_ERR_IMAG, 8'hFF);
    rdc(`DTD_ADDR_PATTERN_CTRL, 8'h41);
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h13);
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h11);
    repeat (60) @(posedge clk);
    rdc(`DTD_ADDR_PATTERN_CTRL, 8'hD1);
    rdc(`DTD_ADDR_ERR_IMAG, 8'h00);
    @(negedge clk) begin
      poly15 = 1'b1;
      invImag = 1'b0;
    end
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h07);
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h05);
    repeat (60) @(posedge clk);
    rdc(`DTD_ADDR_PATTERN_CTRL, 8'hC5);
    wr(`DTD_ADDR_PATTERN_CTRL, 8'h04);
    @(negedge clk) invReal = 1'b1;
    repeat (60) @(posedge clk);
    rdc(`DTD_ADDR_ERR_REAL, 8'h00);
    rdc(`DTD_ADDR_PATTERN_CTRL, 8'h04);
    $display("test pattern checker done");
  endtask : tChecker

  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stopTest

  initial begin
    reset = 1'b1;
    patternValid = 1'b1;
    patternBitReal = 1'b0;
    patternBitImag = 1'b0;
    lfsr = 15'h7FFF;
    poly15 = 1'b0;
    invReal = 1'b0;
    invImag = 1'b0;
    hitReal = 1'b0;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    tResetValues;
    tDecode;
    tDrivePower;
    tChecker;
    stopTest;
  end
endmodule : dtd_reg_bank_tb

`default_nettype wire

// ---- tb/dtd_spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module dtd_spi_host (
  input  wire logic clk,
  output logic      spiClk,
  output logic      spiSelectN,
  output logic      spiDataIn,
  input  wire logic spiDataOut,
  input  wire logic spiDataOutEn
);
  // ------------------------------------------------------------
  // Serial host, clock stands still low between frames
  // ------------------------------------------------------------
  initial begin
    spiClk = 1'b0;
    spiSelectN = 1'b1;
    spiDataIn = 1'b0;
  end

  // High half periods of 6 clk and low ones of 7 clk keep clear of the 4 clk synchroniser minimum
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                      input int nbits, output logic [7:0] rdata);
    logic [23:0] sh;
    sh = {rd, addr, wdata};
    rdata = 8'h00;
    @(posedge clk) #1 spiSelectN = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk) #1 spiDataIn = (rd && i > 15) ? ~spiDataIn : sh[23-i];
      repeat (6) @(posedge clk);
      if (rd && i > 15 && spiDataOutEn) rdata = {rdata[6:0], spiDataOut};
      #1 spiClk = 1'b1;
      repeat (6) @(posedge clk);
      #1 spiClk = 1'b0;
    end
    repeat (6) @(posedge clk);
    #1 spiSelectN = 1'b1;
    spiDataIn = ~spiDataIn;
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : dtd_spi_host

`default_nettype wire
